// File: src/psec_defs.svh
`ifndef PSEC_DEFS_SVH
`define PSEC_DEFS_SVH
// register indices (byte address is four times the index)
`define PSEC_IDX_SUMMARY    5'h10
`define PSEC_IDX_FALSE_CAR  5'h14
`define PSEC_IDX_RX_ERR     5'h15
`define PSEC_IDX_IRQ_STATUS 5'h18
`define PSEC_IDX_IRQ_MASK   5'h19
// summary status field positions
`define PSEC_SUM_LINK       0
`define PSEC_SUM_SPEED10    1
`define PSEC_SUM_DUPLEX     2
`define PSEC_SUM_LOOPBACK   3
`define PSEC_SUM_AN_DONE    4
`define PSEC_SUM_JABBER     5
`define PSEC_SUM_FC_LATCH   11
`define PSEC_SUM_RXE_LATCH  13
// interrupt bit positions
`define PSEC_IRQ_FALSE_CAR  0
`define PSEC_IRQ_RX_ERR     1
`define PSEC_IRQ_LINK_CHG   2
`define PSEC_IRQ_AN_DONE    3
// reset values and counter saturation value
`define PSEC_CNT_RESET      8'h00
`define PSEC_CNT_MAX        8'hFF
`define PSEC_IRQ_RESET      4'h0
`endif

// File: src/psec_pkg.sv
package psec_pkg;
   typedef logic [15:0] psec_word_t;
   typedef logic [4:0]  psec_addr_t;
   typedef logic [3:0]  psec_irq_t;
endpackage : psec_pkg

// File: src/psec_cnt_if.sv
`timescale 1ns/1ps
`default_nettype none
interface psec_cnt_if #(parameter int WIDTH = 8);
   logic             event_pulse;
   logic             clear_rd;
   logic [WIDTH-1:0] count;
   modport ctl (output event_pulse, output clear_rd, input count);
   modport cnt (input event_pulse, input clear_rd, output count);
endinterface : psec_cnt_if
`default_nettype wire

// File: src/psec_sat_counter.sv
`timescale 1ns/1ps
`default_nettype none
`include "psec_defs.svh"
module psec_sat_counter #(
   parameter int WIDTH = 8
) (
   input  wire logic  clk,
   input  wire logic  srst,
   input  wire logic  ce,
   psec_cnt_if.cnt    cif
);
   import psec_pkg::*;

   function automatic logic [WIDTH-1:0] sat_inc(input logic [WIDTH-1:0] v);
      sat_inc = (&v) ? v : v + 1'b1;
   endfunction : sat_inc

   logic [WIDTH-1:0] count;
   assign cif.count = count;

   always_ff @(posedge clk) begin
      if (srst) begin
         count <= '0;
      end else if (ce) begin
         if (cif.clear_rd)
            count <= cif.event_pulse ? WIDTH'(1) : '0;
         else if (cif.event_pulse)
            count <= sat_inc(count);
      end
   end

   a_sat_hold : assert property (@(posedge clk) disable iff (srst)
      ce && (&count) && !cif.clear_rd |=> (&count))
      else $error("counter left its saturated value");
   a_read_race : assert property (@(posedge clk) disable iff (srst)
      ce && cif.clear_rd && cif.event_pulse |=> count == WIDTH'(1))
      else $error("event lost on read of counter");
endmodule : psec_sat_counter
`default_nettype wire

// File: src/psec_carrier_track.sv
`timescale 1ns/1ps
`default_nettype none
module psec_carrier_track (
   input  wire logic clk,
   input  wire logic srst,
   input  wire logic ce,
   input  wire logic carrier,
   input  wire logic symbol_err,
   input  wire logic collision,
   output logic      count_pulse
);
   logic seen_err;
   logic seen_col;
   logic carrier_d;

   always_ff @(posedge clk) begin
      if (srst) begin
         seen_err  <= 1'b0;
         seen_col  <= 1'b0;
         carrier_d <= 1'b0;
      end else if (ce) begin
         carrier_d <= carrier;
         if (carrier) begin
            seen_err <= seen_err | symbol_err;
            seen_col <= seen_col | collision;
         end else begin
            seen_err <= 1'b0;
            seen_col <= 1'b0;
         end
      end
   end

   // one count at end of a carrier event with a symbol error, never with collision
   assign count_pulse = ce && carrier_d && !carrier && seen_err && !seen_col;

   sequence s_col_in_carrier;
      ce && carrier && collision;
   endsequence

   sequence s_carrier_end;
      ce && !carrier;
   endsequence

   a_no_col_count : assert property (@(posedge clk) disable iff (srst)
      s_col_in_carrier ##1 s_carrier_end |-> !count_pulse)
      else $error("receive error counted during collision");
   a_col_marked : assert property (@(posedge clk) disable iff (srst)
      ce && carrier && collision |=> seen_col)
      else $error("collision not marked inside a carrier");
endmodule : psec_carrier_track
`default_nettype wire

// File: src/psec_top.sv
// Local design decision: strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "psec_defs.svh"
module psec_top #(
   parameter int CNT_WIDTH = 8
) (
   input  wire logic             clk,
   input  wire logic             srst,
   input  wire logic             ce,
   input  wire psec_pkg::psec_addr_t addr,
   input  wire psec_pkg::psec_word_t wdata,
   input  wire logic             wr_en,
   input  wire logic             rd_en,
   output psec_pkg::psec_word_t  rdata,
   input  wire logic             jabber,
   input  wire logic             an_done,
   input  wire logic             loopback,
   input  wire logic             full_duplex,
   input  wire logic             speed10,
   input  wire logic             link_ok,
   input  wire logic             false_carrier,
   input  wire logic             carrier,
   input  wire logic             symbol_err,
   input  wire logic             collision,
   output logic                  irq
);
   import psec_pkg::*;

   psec_cnt_if #(.WIDTH(CNT_WIDTH)) fc_if ();
   psec_cnt_if #(.WIDTH(CNT_WIDTH)) re_if ();

   logic      rx_err_pulse;
   logic      fc_latch;
   logic      re_latch;
   logic      link_d;
   logic      an_d;
   psec_irq_t irq_status;
   psec_irq_t irq_mask;
   psec_irq_t irq_event;
   logic      rd_fc;
   logic      rd_re;
   logic      fc_pulse;

   function automatic logic hit(input psec_addr_t a, input psec_addr_t idx, input logic s);
      hit = s && (a == idx);
   endfunction : hit

   assign rd_fc    = ce && hit(addr, `PSEC_IDX_FALSE_CAR, rd_en);
   assign rd_re    = ce && hit(addr, `PSEC_IDX_RX_ERR, rd_en);
   assign fc_pulse = ce && false_carrier;

   assign fc_if.event_pulse = fc_pulse;
   assign fc_if.clear_rd    = rd_fc;
   assign re_if.event_pulse = rx_err_pulse;
   assign re_if.clear_rd    = rd_re;

   psec_carrier_track u_track (
      .clk         (clk),
      .srst        (srst),
      .ce          (ce),
      .carrier     (carrier),
      .symbol_err  (symbol_err),
      .collision   (collision),
      .count_pulse (rx_err_pulse)
   );

   psec_sat_counter #(.WIDTH(CNT_WIDTH)) u_fc_cnt (
      .clk  (clk),
      .srst (srst),
      .ce   (ce),
      .cif  (fc_if.cnt)
   );

   psec_sat_counter #(.WIDTH(CNT_WIDTH)) u_re_cnt (
      .clk  (clk),
      .srst (srst),
      .ce   (ce),
      .cif  (re_if.cnt)
   );

   // latched summary flags: set wins over read clear
   always_ff @(posedge clk) begin
      if (srst) begin
         fc_latch <= 1'b0;
      end else if (ce) begin
         if (fc_pulse)
            fc_latch <= 1'b1;
         else if (rd_fc)
            fc_latch <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         re_latch <= 1'b0;
      end else if (ce) begin
         if (rx_err_pulse)
            re_latch <= 1'b1;
         else if (rd_re)
            re_latch <= 1'b0;
      end
   end

   // interrupt events
   always_ff @(posedge clk) begin
      if (srst) begin
         link_d <= 1'b0;
         an_d   <= 1'b0;
      end else if (ce) begin
         link_d <= link_ok;
         an_d   <= an_done;
      end
   end

   always_comb begin
      irq_event = '0;
      irq_event[`PSEC_IRQ_FALSE_CAR] = fc_pulse;
      irq_event[`PSEC_IRQ_RX_ERR]    = rx_err_pulse;
      irq_event[`PSEC_IRQ_LINK_CHG]  = ce && (link_ok != link_d);
      irq_event[`PSEC_IRQ_AN_DONE]   = ce && an_done && !an_d;
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         irq_status <= `PSEC_IRQ_RESET;
      end else if (ce) begin
         if (hit(addr, `PSEC_IDX_IRQ_STATUS, wr_en))
            irq_status <= (irq_status & ~wdata[3:0]) | irq_event;
         else
            irq_status <= irq_status | irq_event;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         irq_mask <= `PSEC_IRQ_RESET;
      end else if (ce && hit(addr, `PSEC_IDX_IRQ_MASK, wr_en)) begin
         irq_mask <= wdata[3:0];
      end
   end

   always_ff @(posedge clk) begin
      if (srst)
         irq <= 1'b0;
      else if (ce)
         irq <= |(irq_status & irq_mask);
   end

   // read data, one cycle after the strobe; writes to counters ignored
   always_ff @(posedge clk) begin
      if (srst) begin
         rdata <= '0;
      end else if (ce) begin
         rdata <= '0;
         if (rd_en) begin
            unique case (addr)
               `PSEC_IDX_SUMMARY: begin
                  rdata[`PSEC_SUM_JABBER]    <= jabber;
                  rdata[`PSEC_SUM_AN_DONE]   <= an_done;
                  rdata[`PSEC_SUM_LOOPBACK]  <= loopback;
                  rdata[`PSEC_SUM_DUPLEX]    <= full_duplex;
                  rdata[`PSEC_SUM_SPEED10]   <= speed10;
                  rdata[`PSEC_SUM_LINK]      <= link_ok;
                  rdata[`PSEC_SUM_FC_LATCH]  <= fc_latch;
                  rdata[`PSEC_SUM_RXE_LATCH] <= re_latch;
               end
               `PSEC_IDX_FALSE_CAR:  rdata[7:0] <= fc_if.count;
               `PSEC_IDX_RX_ERR:     rdata[7:0] <= re_if.count;
               `PSEC_IDX_IRQ_STATUS: rdata[3:0] <= irq_status;
               `PSEC_IDX_IRQ_MASK:   rdata[3:0] <= irq_mask;
               default:              rdata <= '0;
            endcase
         end
      end
   end

   sequence s_fc_read;
      ce && rd_fc && !fc_pulse;
   endsequence

   a_fc_latch_clr : assert property (@(posedge clk) disable iff (srst)
      s_fc_read |=> !fc_latch)
      else $error("false carrier latch not cleared by read");
   a_re_latch_clr : assert property (@(posedge clk) disable iff (srst)
      ce && rd_re && !rx_err_pulse |=> !re_latch)
      else $error("receive error latch not cleared by read");
   a_fc_read_val : assert property (@(posedge clk) disable iff (srst)
      rd_fc |=> rdata == {8'h00, $past(fc_if.count)})
      else $error("false carrier read value wrong");
   a_re_upper_zero : assert property (@(posedge clk) disable iff (srst)
      rd_re |=> rdata[15:8] == 8'h00)
      else $error("counter upper bits not zero");
   a_summary_link : assert property (@(posedge clk) disable iff (srst)
      ce && rd_en && addr == `PSEC_IDX_SUMMARY |=> rdata[0] == $past(link_ok))
      else $error("link bit does not follow link");
   a_summary_an : assert property (@(posedge clk) disable iff (srst)
      ce && rd_en && addr == `PSEC_IDX_SUMMARY
      |=> rdata[4] == $past(an_done) && rdata[5] == $past(jabber))
      else $error("negotiation or jabber bit wrong");
   a_summary_mode : assert property (@(posedge clk) disable iff (srst)
      ce && rd_en && addr == `PSEC_IDX_SUMMARY
      |=> rdata[2] == $past(full_duplex) && rdata[1] == $past(speed10))
      else $error("duplex or speed bit wrong");

   a_re_read_val : assert property (@(posedge clk) disable iff (srst)
      rd_re |=> rdata == {8'h00, $past(re_if.count)})
      else $error("receive error read value wrong");
   a_fc_upper_zero : assert property (@(posedge clk) disable iff (srst)
      rd_fc |=> rdata[15:8] == 8'h00)
      else $error("false carrier upper bits not zero");

   // summary contents and its side effects
   sequence s_sum_read;
      ce && hit(addr, `PSEC_IDX_SUMMARY, rd_en);
   endsequence

   a_sum_latches : assert property (@(posedge clk) disable iff (srst)
      s_sum_read |=> rdata[`PSEC_SUM_RXE_LATCH] == $past(re_latch)
      && rdata[`PSEC_SUM_FC_LATCH] == $past(fc_latch))
      else $error("summary latch bits wrong");
   a_sum_loopback : assert property (@(posedge clk) disable iff (srst)
      s_sum_read |=> rdata[`PSEC_SUM_LOOPBACK] == $past(loopback))
      else $error("loopback bit wrong");
   a_sum_reserved : assert property (@(posedge clk) disable iff (srst)
      s_sum_read |=> rdata[15:14] == 2'h0 && rdata[12] == 1'b0 && rdata[10:6] == 5'h00)
      else $error("summary reserved bits not zero");
   a_sum_keeps_fc : assert property (@(posedge clk) disable iff (srst)
      ce && hit(addr, `PSEC_IDX_SUMMARY, rd_en) && fc_latch |=> fc_latch)
      else $error("summary read cleared false carrier latch");
   a_sum_keeps_re : assert property (@(posedge clk) disable iff (srst)
      ce && hit(addr, `PSEC_IDX_SUMMARY, rd_en) && re_latch |=> re_latch)
      else $error("summary read cleared receive error latch");

   // read port and clock enable
   a_rdata_idle : assert property (@(posedge clk) disable iff (srst)
      ce && !rd_en |=> rdata == 16'h0000)
      else $error("read data not zero outside a read");
   a_unmapped_zero : assert property (@(posedge clk) disable iff (srst)
      ce && rd_en && !(addr inside {`PSEC_IDX_SUMMARY, `PSEC_IDX_FALSE_CAR, `PSEC_IDX_RX_ERR,
         `PSEC_IDX_IRQ_STATUS, `PSEC_IDX_IRQ_MASK}) |=> rdata == 16'h0000)
      else $error("unmapped register read not zero");
   a_ce_freeze : assert property (@(posedge clk) disable iff (srst)
      !ce |=> $stable(rdata) && $stable(irq) && $stable(fc_if.count) && $stable(re_if.count))
      else $error("state moved while clock enable low");

   // counter behaviour seen from the register side
   a_fc_inc : assert property (@(posedge clk) disable iff (srst)
      fc_pulse && !rd_fc && !(&fc_if.count) |=> fc_if.count == $past(fc_if.count) + 1'b1)
      else $error("false carrier count did not step");
   a_re_inc : assert property (@(posedge clk) disable iff (srst)
      rx_err_pulse && !rd_re && !(&re_if.count) |=> re_if.count == $past(re_if.count) + 1'b1)
      else $error("receive error count did not step");
   a_fc_stick : assert property (@(posedge clk) disable iff (srst)
      fc_pulse && !rd_fc && (&fc_if.count) |=> &fc_if.count)
      else $error("false carrier count wrapped");
   a_re_stick : assert property (@(posedge clk) disable iff (srst)
      rx_err_pulse && !rd_re && (&re_if.count) |=> &re_if.count)
      else $error("receive error count wrapped");
   a_fc_clear : assert property (@(posedge clk) disable iff (srst)
      rd_fc && !fc_pulse |=> fc_if.count == '0)
      else $error("false carrier count not cleared by read");
   a_re_clear : assert property (@(posedge clk) disable iff (srst)
      rd_re && !rx_err_pulse |=> re_if.count == '0)
      else $error("receive error count not cleared by read");
   a_fc_race : assert property (@(posedge clk) disable iff (srst)
      rd_fc && fc_pulse |=> fc_if.count == CNT_WIDTH'(1) && fc_latch)
      else $error("false carrier event lost on read");
   a_cnt_wr_ignored : assert property (@(posedge clk) disable iff (srst)
      ce && wr_en && !rd_en && !fc_pulse && !rx_err_pulse
      && (addr == `PSEC_IDX_FALSE_CAR || addr == `PSEC_IDX_RX_ERR)
      |=> $stable(fc_if.count) && $stable(re_if.count))
      else $error("write changed a counter");
   a_re_once : assert property (@(posedge clk) disable iff (srst)
      rx_err_pulse |=> !rx_err_pulse)
      else $error("receive error counted twice in one carrier");
   a_fc_latch_set : assert property (@(posedge clk) disable iff (srst)
      fc_pulse |=> fc_latch)
      else $error("false carrier latch not set");
   a_re_latch_set : assert property (@(posedge clk) disable iff (srst)
      rx_err_pulse |=> re_latch)
      else $error("receive error latch not set");

   // interrupt status, mask and output
   a_irq_clear : assert property (@(posedge clk) disable iff (srst)
      ce && hit(addr, `PSEC_IDX_IRQ_STATUS, wr_en) && !(|irq_event)
      |=> (irq_status & $past(wdata[3:0])) == 4'h0)
      else $error("interrupt status not cleared by write of one");
   a_irq_set_wins : assert property (@(posedge clk) disable iff (srst)
      (|irq_event) |=> (irq_status & $past(irq_event)) == $past(irq_event))
      else $error("interrupt event lost");
   a_irq_link_evt : assert property (@(posedge clk) disable iff (srst)
      ce && (link_ok != link_d) |=> irq_status[`PSEC_IRQ_LINK_CHG])
      else $error("link change not flagged");
   a_irq_an_evt : assert property (@(posedge clk) disable iff (srst)
      ce && an_done && !an_d |=> irq_status[`PSEC_IRQ_AN_DONE])
      else $error("negotiation done not flagged");
   a_mask_write : assert property (@(posedge clk) disable iff (srst)
      ce && hit(addr, `PSEC_IDX_IRQ_MASK, wr_en) |=> irq_mask == $past(wdata[3:0]))
      else $error("interrupt mask not written");
   a_irq_level : assert property (@(posedge clk) disable iff (srst)
      ce |=> irq == $past(|(irq_status & irq_mask)))
      else $error("interrupt output does not follow status and mask");
   a_irq_status_read : assert property (@(posedge clk) disable iff (srst)
      ce && hit(addr, `PSEC_IDX_IRQ_STATUS, rd_en)
      |=> rdata == {12'h000, $past(irq_status)})
      else $error("interrupt status read value wrong");

   // reset, and an event followed by a read of its counter
   sequence s_fc_event;
      fc_pulse;
   endsequence

   sequence s_re_event;
      rx_err_pulse;
   endsequence

   sequence s_re_read;
      ce && rd_re && !rx_err_pulse;
   endsequence

   a_reset_clear : assert property (@(posedge clk)
      srst |=> rdata == 16'h0000 && !irq && fc_if.count == '0 && re_if.count == '0
      && !fc_latch && !re_latch && irq_status == 4'h0 && irq_mask == 4'h0)
      else $error("state not cleared by reset");
   a_fc_event_read : assert property (@(posedge clk) disable iff (srst)
      s_fc_event ##[1:3] s_fc_read |=> rdata[7:0] != 8'h00 && !fc_latch)
      else $error("false carrier event missing from read");
   a_re_event_read : assert property (@(posedge clk) disable iff (srst)
      s_re_event ##[1:3] s_re_read |=> rdata[7:0] != 8'h00 && !re_latch)
      else $error("receive error event missing from read");
endmodule : psec_top
`default_nettype wire

// File: verif/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
   import psec_pkg::*;
   logic       clk = 1'b0, srst = 1'b1, ce = 1'b1, wr_en = 1'b0, rd_en = 1'b0, irq;
   psec_addr_t addr = 5'h00;
   psec_word_t wdata = 16'h0000, rdata;
   logic       jabber = 1'b0, an_done = 1'b0, loopback = 1'b0, full_duplex = 1'b0;
   logic       speed10 = 1'b0, link_ok = 1'b0, false_carrier = 1'b0, carrier = 1'b0;
   logic       symbol_err = 1'b0, collision = 1'b0;
   int         mismatches = 0, checked = 0;
   int         fc = 0, re = 0, fl = 0, rl = 0, ist = 0, msk = 0, st = 0;
   psec_addr_t expv_list[6] = '{5'h14, 5'h15, 5'h18, 5'h19, 5'h03, 5'h1F};
   psec_top u_dut (.clk(clk), .srst(srst), .ce(ce), .addr(addr), .wdata(wdata),
      .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .jabber(jabber), .an_done(an_done),
      .loopback(loopback), .full_duplex(full_duplex), .speed10(speed10),
      .link_ok(link_ok), .false_carrier(false_carrier), .carrier(carrier),
      .symbol_err(symbol_err), .collision(collision), .irq(irq));
   always #5 clk = ~clk;
   task automatic chk(input psec_word_t seen, input psec_word_t exp);
      checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   function automatic psec_word_t expv(input psec_addr_t a);
      case (a)
         5'h10: return psec_word_t'((rl << 13) | (fl << 11) | st);
         5'h14: return psec_word_t'(fc);
         5'h15: return psec_word_t'(re);
         5'h18: return psec_word_t'(ist);
         5'h19: return psec_word_t'(msk);
         default: return 16'h0000;
      endcase
   endfunction : expv
   task automatic rd(input psec_addr_t a);
      @(posedge clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clk);
      rd_en <= 1'b0;
      #1 chk(rdata, expv(a));
      if (a == 5'h14) begin
         fc = 0;
         fl = 0;
      end
      if (a == 5'h15) begin
         re = 0;
         rl = 0;
      end
   endtask : rd
   task automatic wr(input psec_addr_t a, input psec_word_t d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr_en <= 1'b1;
      @(posedge clk);
      wr_en <= 1'b0;
      if (a == 5'h18) ist &= ~int'(d);
      if (a == 5'h19) msk = int'(d[3:0]);
   endtask : wr
   task automatic fcp();
      @(posedge clk);
      false_carrier <= 1'b1;
      @(posedge clk);
      false_carrier <= 1'b0;
      if (ce) begin
         fc = (fc < 255) ? fc + 1 : 255;
         fl = 1;
         ist |= 1;
      end
   endtask : fcp
   task automatic frame(input logic err, input logic col);
      @(posedge clk);
      carrier <= 1'b1;
      symbol_err <= err;
      collision <= col;
      repeat (3) @(posedge clk);
      carrier <= 1'b0;
      symbol_err <= 1'b0;
      collision <= 1'b0;
      repeat (2) @(posedge clk);
      if (err && !col) begin
         re = (re < 255) ? re + 1 : 255;
         rl = 1;
         ist |= 2;
      end
   endtask : frame
   task automatic sts(input logic [5:0] v);
      @(posedge clk);
      {jabber, an_done, loopback, full_duplex, speed10, link_ok} <= v;
      if (v[0] != st[0]) ist |= 4;
      if (v[4] && !st[4]) ist |= 8;
      st = int'(v);
      repeat (2) @(posedge clk);
   endtask : sts
   task automatic irqchk(input logic e);
      repeat (3) @(posedge clk);
      #1 chk({15'h0000, irq}, {15'h0000, e});
   endtask : irqchk
   task automatic summarize();
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : summarize
   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      summarize();
   end
   initial begin
      repeat (3) @(posedge clk);
      srst <= 1'b0;
      void'($urandom(81));
      foreach (expv_list[i]) rd(expv_list[i]);
      $display("reset and unmapped test done");
      for (int i = 0; i < 6; i++) begin
         sts(6'($urandom));
         rd(5'h10);
         rd(5'h10);
      end
      sts(6'h17);
      rd(5'h10);
      $display("summary test done");
      repeat (1 + $urandom % 5) fcp();
      rd(5'h10);
      wr(5'h14, 16'hFFFF);
      rd(5'h14);
      rd(5'h10);
      frame(1'b1, 1'b0);
      frame(1'b1, 1'b1);
      frame(1'b0, 1'b0);
      frame(1'b1, 1'b0);
      wr(5'h15, 16'hFFFF);
      rd(5'h10);
      rd(5'h15);
      rd(5'h10);
      $display("counter test done");
      repeat (260) fcp();
      rd(5'h14);
      repeat (257) frame(1'b1, 1'b0);
      rd(5'h15);
      $display("saturation test done");
      fcp();
      @(posedge clk);
      addr <= 5'h14;
      rd_en <= 1'b1;
      false_carrier <= 1'b1;
      @(posedge clk);
      rd_en <= 1'b0;
      false_carrier <= 1'b0;
      #1 chk(rdata, 16'h0001);
      ist |= 1;
      rd(5'h10);
      rd(5'h14);
      @(posedge clk);
      ce <= 1'b0;
      fcp();
      ce <= 1'b1;
      rd(5'h14);
      $display("read collision test done");
      wr(5'h18, 16'h000F);
      wr(5'h19, 16'h0001);
      irqchk(1'b0);
      fcp();
      irqchk(1'b1);
      rd(5'h18);
      wr(5'h18, 16'h0001);
      irqchk(1'b0);
      frame(1'b1, 1'b0);
      irqchk(1'b0);
      wr(5'h19, 16'h000F);
      irqchk(1'b1);
      rd(5'h19);
      wr(5'h18, 16'h000F);
      irqchk(1'b0);
      $display("interrupt test done");
      summarize();
   end
endmodule : tb
`default_nettype wire
